// ### flash_status_defines.svh
`ifndef FLASH_STATUS_DEFINES_SVH
`define FLASH_STATUS_DEFINES_SVH

// Command codes on the low data byte; query address on the low address byte
`define CMD_QUERY_ENTRY 8'h98
`define CMD_QUERY_ADDR 8'h55
`define CMD_RESET 8'hF0
`define CMD_UNLOCK1 8'hAA
`define CMD_UNLOCK2 8'h55
`define CMD_ERASE_SETUP 8'h80
`define CMD_BLOCK_ERASE 8'h30
`define CMD_CHIP_ERASE 8'h10
`define CMD_PROGRAM 8'hA0
`define CMD_SUSPEND 8'hB0
`define CMD_RESUME 8'h30

// Status bit positions on the data bus
`define BIT_EXCEEDED 5
`define BIT_ERASE_WINDOW 3
`define BIT_TOGGLE2 2

// Timing
`define CLK_PERIOD_NS 40
`define ERASE_WINDOW_US 50
`define ERASE_WINDOW_CYC ((`ERASE_WINDOW_US * 1000) / `CLK_PERIOD_NS)

// Query space
`define QRY_ADDR_W 7
`define QRY_UPPER_BYTE 8'h00

`endif

// ### flash_status_pkg.sv
package flash_status_pkg;

    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_WINDOW = 6'b000010,
        ST_ERASE = 6'b000100,
        ST_PROG = 6'b001000,
        ST_ESUSP = 6'b010000,
        ST_PSUSP = 6'b100000
    } op_state_type;

    typedef enum logic [2:0] {
        CS_NONE = 3'b001,
        CS_U1 = 3'b010,
        CS_U2 = 3'b100
    } cmd_step_type;

endpackage

// ### query_rom.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_status_defines.svh"

module query_rom (
    input wire logic [`QRY_ADDR_W-1:0] addr_in, // Query word address
    output logic [7:0] data_out // Query byte
);

    // =========================================================
    // Query table
    always_comb begin
        case (addr_in)
            7'h10: data_out = 8'h51; // R15
            7'h11: data_out = 8'h52; // R15
            7'h12: data_out = 8'h59; // R15
            7'h13: data_out = 8'h02; // R16
            7'h15: data_out = 8'h40; // R16
            7'h1B: data_out = 8'h17;
            7'h1C: data_out = 8'h19;
            7'h1D: data_out = 8'h85;
            7'h1E: data_out = 8'h95;
            7'h1F: data_out = 8'h04; // R17
            7'h21: data_out = 8'h0A; // R17
            7'h22: data_out = 8'h11; // R17
            7'h23: data_out = 8'h05; // R18
            7'h25: data_out = 8'h04; // R18
            7'h27: data_out = 8'h16;
            7'h2C: data_out = 8'h02; // R19
            7'h2D: data_out = 8'h07; // R19
            7'h2F: data_out = 8'h20; // R19
            7'h31: data_out = 8'h3E; // R19
            7'h34: data_out = 8'h01; // R19
            7'h40: data_out = 8'h50; // R20
            7'h41: data_out = 8'h52; // R20
            7'h42: data_out = 8'h49; // R20
            7'h43: data_out = 8'h35; // R20
            7'h44: data_out = 8'h30; // R20
            7'h46: data_out = 8'h02; // R21
            7'h47: data_out = 8'h01; // R21
            7'h49: data_out = 8'h01;
            7'h4A: data_out = 8'h01;
            7'h4B: data_out = 8'h01;
            7'h4D: data_out = 8'h03;
            7'h4E: data_out = 8'h42;
            7'h50: data_out = 8'h01; // R22
            default: data_out = 8'h00;
        endcase
    end

endmodule
`default_nettype wire

// ### erase_window_timer.sv
`timescale 1ns/1ns
`default_nettype none
`include "flash_status_defines.svh"

module erase_window_timer #(
    parameter int WINDOW_CYC = `ERASE_WINDOW_CYC
) (
    input wire logic mclk_in, // Clock
    input wire logic rst_b_in, // Async reset, active low
    input wire logic restart_in, // Start or restart the window
    input wire logic run_in, // Window open
    output logic expired_out // Pulse at window end
);

    localparam int CW = $clog2(WINDOW_CYC + 1);

    // Elaboration check on the window length
    if (WINDOW_CYC < 2) begin : g_window_check
        $error("WINDOW_CYC too small");
    end

    logic [CW-1:0] cnt_r;
    logic [CW-1:0] cnt_nxt;

    // =========================================================
    // Window counter
    always_comb begin
        cnt_nxt = cnt_r;
        if (restart_in) begin
            cnt_nxt = CW'(WINDOW_CYC - 1);
        end else if (run_in && cnt_r != '0) begin
            cnt_nxt = cnt_r - CW'(1);
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end

    assign expired_out = run_in && !restart_in && cnt_r == CW'(1); // R02

endmodule
`default_nettype wire

// ### flash_status_query.sv
// Function
// R01: Program or erase overrunning its time limit raises exceeded flag bit 5.
// R02: Erase window flag bit 3 rises after 50 us; erase then starts.
// R03: After window expiry, writes are ignored until erase completes; the code accepts the B0H suspend command while the exceeded flag is clear.
// R04: Within the window, further 30H block erase commands add blocks.
// R05: Erase window flag stays low while the window is open.
// R06: Host should read bit 3 after each block erase command.
// R07: Bit 2 toggles only during erase or suspend, on erasing block reads.
// R08: In suspend, bit 2 toggles for suspended block, else array data.
// R09: Programming a non-suspended block in erase suspend drives bit 2 high.
// R10: Data-valid output high when burst data valid, low otherwise.
// R11: Chip select low with output enable high holds data-valid high.
// R12: Writing 98H to word address 55H enters query mode.
// R13: Query bytes on bits 7..0, upper byte reads 00h.
// R14: Host leaves query mode with the reset command.
// R15: Query addresses 10H..12H read Q, R, Y.
// R16: Command set at 13H..14H, extended table address 0040H at 15H.
// R17: Typical timeouts 0004H, 000AH, 0011H at 1FH, 21H, 22H.
// R18: Maximum timeouts 0005H at 23H, 0004H at 25H, others zero.
// R19: Two erase regions at 2CH with the given region words.
// R20: Extended table P, R, I at 40H..42H, versions 35H and 30H.
// R21: Erase suspend 0002H at 46H, block protect 0001H at 47H.
// R22: Address 50H reads 0001H for synchronous handshaking.
// R23: Reset command in query mode restores array reads.
`timescale 1ns/1ns
`default_nettype none
`include "flash_status_defines.svh"

module flash_status_query
    import flash_status_pkg::*;
#(
    parameter int ADDR_W = 21,
    parameter int BLK_W = 6,
    parameter int WINDOW_CYC = `ERASE_WINDOW_CYC
) (
    input wire logic mclk_in, // Burst clock
    input wire logic rst_b_in, // Hardware reset, active low
    input wire logic ce_b_in, // Chip select, active low
    input wire logic oe_b_in, // Output enable, active low
    input wire logic we_b_in, // Write strobe, active low
    input wire logic [ADDR_W-1:0] addr_in, // Word address
    input wire logic [15:0] wdata_in, // Write data
    input wire logic [15:0] array_data_in, // Array data at addr_in
    input wire logic burst_valid_in, // Burst data ready next edge
    input wire logic op_done_in, // Internal routine finished
    input wire logic time_limit_in, // Internal routine overran
    output logic [15:0] rdata_out, // Read data
    output logic rdy_out, // Burst data valid
    output logic erase_start_out, // Block erase begins at window end (pulse)
    output logic [ADDR_W-1:0] erase_blk_mask_out, // Unused high bits zero
    output logic query_mode_out, // Query space mapped
    output logic busy_out // Any state but idle: window, erase, program or suspend
);

    localparam int NBLK = 1 << BLK_W;

    // Elaboration check on the address split
    if (ADDR_W < BLK_W + `QRY_ADDR_W || BLK_W < 1) begin : g_addr_check
        $error("ADDR_W too small for BLK_W");
    end

    function automatic logic [BLK_W-1:0] blk_of(input logic [ADDR_W-1:0] a);
        blk_of = a[ADDR_W-1 -: BLK_W];
    endfunction

    // =========================================================
    // Write and read strobes: one pulse per write or read cycle
    logic we_d_r;
    logic wr_cyc;
    logic wr_pulse;
    logic rd_cyc;
    logic rd_pulse;
    logic rd_d_r;
    assign wr_cyc = !ce_b_in && !we_b_in && oe_b_in;
    assign wr_pulse = wr_cyc && !we_d_r;
    assign rd_cyc = !ce_b_in && !oe_b_in && we_b_in;
    assign rd_pulse = rd_cyc && !rd_d_r;

    // =========================================================
    // Operation state
    op_state_type st_r, st_nxt;
    cmd_step_type cs_r, cs_nxt;
    logic erase_cmd_r, erase_cmd_nxt;
    logic prog_cmd_r, prog_cmd_nxt;
    logic query_r, query_nxt;
    logic exceeded_r, exceeded_nxt;
    logic win_flag_r, win_flag_nxt;
    logic tog2_r, tog2_nxt;
    logic bad_prog_r, bad_prog_nxt;
    logic [NBLK-1:0] blk_r, blk_nxt;
    logic [BLK_W-1:0] pblk_r, pblk_nxt;
    logic win_restart;
    logic win_expired;
    logic [7:0] wbyte;
    logic [BLK_W-1:0] wblk;
    logic [BLK_W-1:0] rblk;
    logic [7:0] qbyte;

    assign wbyte = wdata_in[7:0];
    assign wblk = blk_of(addr_in);
    assign rblk = blk_of(addr_in);

    erase_window_timer #(
        .WINDOW_CYC(WINDOW_CYC)
    ) u_timer (
        .mclk_in(mclk_in),
        .rst_b_in(rst_b_in),
        .restart_in(win_restart),
        .run_in(st_r == ST_WINDOW),
        .expired_out(win_expired)
    );

    query_rom u_rom (
        .addr_in(addr_in[`QRY_ADDR_W-1:0]),
        .data_out(qbyte)
    );

    always_comb begin
        st_nxt = st_r;
        cs_nxt = cs_r;
        erase_cmd_nxt = erase_cmd_r;
        prog_cmd_nxt = prog_cmd_r;
        query_nxt = query_r;
        exceeded_nxt = exceeded_r;
        win_flag_nxt = win_flag_r;
        tog2_nxt = tog2_r;
        bad_prog_nxt = bad_prog_r;
        blk_nxt = blk_r;
        pblk_nxt = pblk_r;
        win_restart = 1'b0;
        if (rd_pulse) begin
            tog2_nxt = !tog2_r;
        end
        if (time_limit_in && (st_r == ST_ERASE || st_r == ST_PROG)) begin
            exceeded_nxt = 1'b1; // R01
        end
        case (st_r)
            ST_IDLE: begin
                if (wr_pulse) begin
                    if (wbyte == `CMD_RESET) begin
                        query_nxt = 1'b0; // R23
                        cs_nxt = CS_NONE;
                        exceeded_nxt = 1'b0;
                    end else if (wbyte == `CMD_QUERY_ENTRY &&
                                 addr_in[7:0] == `CMD_QUERY_ADDR) begin
                        query_nxt = 1'b1; // R12
                    end else if (prog_cmd_r) begin
                        prog_cmd_nxt = 1'b0;
                        pblk_nxt = wblk;
                        st_nxt = ST_PROG;
                    end else begin
                        case (cs_r)
                            CS_NONE: begin
                                if (wbyte == `CMD_UNLOCK1) begin
                                    cs_nxt = CS_U1;
                                end
                            end
                            CS_U1: begin
                                cs_nxt = (wbyte == `CMD_UNLOCK2) ?
                                         CS_U2 : CS_NONE;
                            end
                            CS_U2: begin
                                cs_nxt = CS_NONE;
                                if (wbyte == `CMD_ERASE_SETUP) begin
                                    erase_cmd_nxt = 1'b1;
                                end else if (wbyte == `CMD_PROGRAM) begin
                                    prog_cmd_nxt = 1'b1;
                                end else if (erase_cmd_r &&
                                             wbyte == `CMD_BLOCK_ERASE) begin
                                    erase_cmd_nxt = 1'b0;
                                    blk_nxt = '0;
                                    blk_nxt[wblk] = 1'b1;
                                    win_flag_nxt = 1'b0;
                                    win_restart = 1'b1;
                                    st_nxt = ST_WINDOW;
                                end else if (erase_cmd_r &&
                                             wbyte == `CMD_CHIP_ERASE) begin
                                    erase_cmd_nxt = 1'b0;
                                    blk_nxt = '1;
                                    win_flag_nxt = 1'b1;
                                    st_nxt = ST_ERASE;
                                end
                            end
                            default: cs_nxt = CS_NONE;
                        endcase
                    end
                end
            end
            ST_WINDOW: begin
                if (wr_pulse && wbyte == `CMD_BLOCK_ERASE) begin
                    blk_nxt[wblk] = 1'b1; // R04
                    win_restart = 1'b1;
                end else if (win_expired) begin
                    win_flag_nxt = 1'b1; // R02
                    st_nxt = ST_ERASE;
                end
            end
            ST_ERASE: begin
                // Writes are ignored here except suspend while the exceeded flag is clear
                if (op_done_in) begin // R03
                    st_nxt = ST_IDLE;
                    win_flag_nxt = 1'b0;
                    if (!exceeded_r) begin
                        blk_nxt = '0;
                    end
                end else if (wr_pulse && wbyte == `CMD_SUSPEND &&
                             !exceeded_r) begin
                    st_nxt = ST_ESUSP;
                end
            end
            ST_PROG: begin
                if (op_done_in) begin
                    st_nxt = bad_prog_r ? ST_ESUSP : ST_IDLE;
                end else if (wr_pulse && wbyte == `CMD_SUSPEND &&
                             !bad_prog_r) begin
                    st_nxt = ST_PSUSP;
                end
            end
            ST_ESUSP: begin
                if (wr_pulse && wbyte == `CMD_RESUME) begin
                    st_nxt = ST_ERASE;
                    bad_prog_nxt = 1'b0;
                end else if (wr_pulse && wbyte == `CMD_PROGRAM) begin
                    prog_cmd_nxt = 1'b1;
                end else if (wr_pulse && prog_cmd_r) begin
                    prog_cmd_nxt = 1'b0;
                    pblk_nxt = wblk;
                    bad_prog_nxt = !blk_r[wblk]; // R09
                    st_nxt = ST_PROG;
                end
            end
            ST_PSUSP: begin
                if (wr_pulse && wbyte == `CMD_RESUME) begin
                    st_nxt = ST_PROG;
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            st_r <= ST_IDLE;
            cs_r <= CS_NONE;
            erase_cmd_r <= 1'b0;
            prog_cmd_r <= 1'b0;
            query_r <= 1'b0;
            exceeded_r <= 1'b0;
            win_flag_r <= 1'b0;
            tog2_r <= 1'b0;
            bad_prog_r <= 1'b0;
            blk_r <= '0;
            pblk_r <= '0;
            we_d_r <= 1'b0;
            rd_d_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cs_r <= cs_nxt;
            erase_cmd_r <= erase_cmd_nxt;
            prog_cmd_r <= prog_cmd_nxt;
            query_r <= query_nxt;
            exceeded_r <= exceeded_nxt;
            win_flag_r <= win_flag_nxt;
            tog2_r <= tog2_nxt;
            bad_prog_r <= bad_prog_nxt;
            blk_r <= blk_nxt;
            pblk_r <= pblk_nxt;
            we_d_r <= wr_cyc;
            rd_d_r <= rd_cyc;
        end
    end

    // =========================================================
    // Read data path
    logic [15:0] rdata_nxt;
    logic erasing_blk;
    logic in_erase;
    assign in_erase = st_r == ST_WINDOW || st_r == ST_ERASE;
    assign erasing_blk = blk_r[rblk];

    always_comb begin
        rdata_nxt = array_data_in;
        if (query_r) begin
            rdata_nxt = {`QRY_UPPER_BYTE, qbyte}; // R13
        end else if (in_erase && erasing_blk) begin
            rdata_nxt = 16'h0000;
            rdata_nxt[`BIT_EXCEEDED] = exceeded_r; // R01
            rdata_nxt[`BIT_ERASE_WINDOW] = win_flag_r; // R05
            rdata_nxt[`BIT_TOGGLE2] = tog2_r; // R07
        end else if (st_r == ST_PROG && rblk == pblk_r) begin
            rdata_nxt = 16'h0000;
            rdata_nxt[`BIT_EXCEEDED] = exceeded_r;
            rdata_nxt[`BIT_TOGGLE2] = 1'b1; // R09
        end else if (st_r == ST_ESUSP && erasing_blk) begin
            rdata_nxt = 16'h0000;
            rdata_nxt[`BIT_TOGGLE2] = tog2_r; // R08
        end else if (st_r == ST_PSUSP && rblk == pblk_r) begin
            rdata_nxt = 16'h0000;
            rdata_nxt[`BIT_TOGGLE2] = tog2_r; // R08
        end
    end

    always_ff @(posedge mclk_in or negedge rst_b_in) begin
        if (!rst_b_in) begin
            rdata_out <= 16'h0000;
        end else begin
            rdata_out <= rdata_nxt;
        end
    end

    // =========================================================
    // Outputs
    assign rdy_out = (!ce_b_in && oe_b_in) ? 1'b1 : burst_valid_in; // R10 R11
    assign erase_start_out = st_r == ST_WINDOW && st_nxt == ST_ERASE;
    assign query_mode_out = query_r;
    assign busy_out = st_r != ST_IDLE;
    assign erase_blk_mask_out = ADDR_W'(blk_r[BLK_W-1:0]);

    // =========================================================
    // Checks
    rdy_hold_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // R11
        (!ce_b_in && oe_b_in) |-> rdy_out)
        else $error("data-valid not high when deselected output");
    win_low_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // R05
        (st_r == ST_WINDOW) |-> !win_flag_r)
        else $error("window flag high while window open");
    win_rise_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // R02
        (st_r == ST_WINDOW && win_expired && !wr_pulse) |=>
        (win_flag_r && st_r == ST_ERASE))
        else $error("erase did not start at window end");
    query_in_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // R12
        (st_r == ST_IDLE && wr_pulse && wbyte == `CMD_QUERY_ENTRY &&
         addr_in[7:0] == `CMD_QUERY_ADDR) |=> query_r)
        else $error("query entry missed");
    query_out_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // R23
        (query_r && st_r == ST_IDLE && wr_pulse && wbyte == `CMD_RESET)
        |=> !query_r ##1 (rdata_out == $past(array_data_in)))
        else $error("reset did not leave query mode");
    query_up_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // R13
        query_r |=> rdata_out[15:8] == 8'h00)
        else $error("query upper byte not zero");
    erase_ign_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // R03
        (st_r == ST_ERASE && !op_done_in && wbyte != `CMD_SUSPEND)
        |=> $stable(blk_r) && st_r == ST_ERASE)
        else $error("write accepted during erase");
    add_blk_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // R04
        (st_r == ST_WINDOW && wr_pulse && wbyte == `CMD_BLOCK_ERASE)
        |=> blk_r[$past(wblk)] && st_r == ST_WINDOW)
        else $error("extra block erase not accepted");
    exceed_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // R01
        (st_r == ST_ERASE && time_limit_in && !op_done_in) |=> exceeded_r)
        else $error("exceeded flag not raised");
    qry_sig_a: assert property (@(posedge mclk_in) disable iff (!rst_b_in) // R15
        (query_r && addr_in[`QRY_ADDR_W-1:0] == 7'h10) |=>
        rdata_out == 16'h0051)
        else $error("query signature wrong");

endmodule
`default_nettype wire

// ### array_model.sv
`timescale 1ns/1ns
`default_nettype none
module array_model (
    input wire logic mclk_in, // Clock
    input wire logic [20:0] addr_in, // Word address
    input wire logic finish_in, // Request end of routine
    input wire logic overrun_in, // Request time limit fault
    output logic [15:0] array_data_out, // Array word at addr_in
    output logic op_done_out, // Routine finished pulse
    output logic time_limit_out // Routine overran pulse
);
    // Contents depend on address so misrouted reads show up
    assign array_data_out = addr_in[15:0] ^ 16'hA5C3;
    always_ff @(posedge mclk_in) begin
        op_done_out <= finish_in;
        time_limit_out <= overrun_in;
    end
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    localparam int WCYC = 20;
    localparam logic [7:0] QA [0:31] = '{8'h10, 8'h11, 8'h12, 8'h13, 8'h14,
        8'h15, 8'h16, 8'h1F, 8'h21, 8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h2C,
        8'h2D, 8'h2E, 8'h2F, 8'h30, 8'h31, 8'h32, 8'h33, 8'h34, 8'h35, 8'h40,
        8'h41, 8'h42, 8'h43, 8'h44, 8'h46, 8'h47, 8'h50};
    localparam logic [7:0] QD [0:31] = '{8'h51, 8'h52, 8'h59, 8'h02, 8'h00,
        8'h40, 8'h00, 8'h04, 8'h0A, 8'h11, 8'h05, 8'h00, 8'h04, 8'h00, 8'h02,
        8'h07, 8'h00, 8'h20, 8'h00, 8'h3E, 8'h00, 8'h00, 8'h01, 8'h00, 8'h50,
        8'h52, 8'h49, 8'h35, 8'h30, 8'h02, 8'h01, 8'h01};
    logic mclk_in = 1'b0;
    logic rst_b = 1'b0;
    logic ce_b = 1'b1;
    logic oe_b = 1'b1;
    logic we_b = 1'b1;
    logic [20:0] addr = '0;
    logic [15:0] wdata = '0;
    logic burst_valid = 1'b0;
    logic finish = 1'b0;
    logic overrun = 1'b0;
    logic [15:0] array_data, rdata_out, d0, d1;
    logic op_done, time_limit, rdy_out, erase_start_out, query_mode_out;
    logic busy_out;
    logic [20:0] erase_blk_mask_out;
    int bad_count = 0;
    int tests_run = 0;
    int cycles = 0;
    int n;

    always #20 mclk_in = ~mclk_in;

    flash_status_query #(.WINDOW_CYC(WCYC)) dut_u (.mclk_in(mclk_in),
        .rst_b_in(rst_b), .ce_b_in(ce_b), .oe_b_in(oe_b), .we_b_in(we_b),
        .addr_in(addr), .wdata_in(wdata), .array_data_in(array_data),
        .burst_valid_in(burst_valid), .op_done_in(op_done),
        .time_limit_in(time_limit), .rdata_out(rdata_out), .rdy_out(rdy_out),
        .erase_start_out(erase_start_out),
        .erase_blk_mask_out(erase_blk_mask_out),
        .query_mode_out(query_mode_out), .busy_out(busy_out));
    array_model far_u (.mclk_in(mclk_in), .addr_in(addr), .finish_in(finish),
        .overrun_in(overrun), .array_data_out(array_data),
        .op_done_out(op_done), .time_limit_out(time_limit));

    // ========================================
    // Access tasks
    task automatic report_and_stop();
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic chk(input string what, input logic [15:0] e,
                       input logic [15:0] g);
        tests_run++;
        if (e !== g) begin
            bad_count++;
            $display("unexpected %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic wr(input logic [20:0] a, input logic [7:0] c);
        @(posedge mclk_in);
        addr <= a;
        wdata <= {8'h00, c};
        we_b <= 1'b0;
        @(posedge mclk_in);
        we_b <= 1'b1;
    endtask
    task automatic rd(input logic [20:0] a, output logic [15:0] d);
        @(posedge mclk_in);
        addr <= a;
        oe_b <= 1'b0;
        repeat (2) @(posedge mclk_in);
        #1 d = rdata_out;
        @(posedge mclk_in);
        oe_b <= 1'b1;
    endtask
    task automatic ers(input logic [5:0] b);
        wr(21'h555, 8'hAA);
        wr(21'h2AA, 8'h55);
        wr(21'h555, 8'h80);
        wr(21'h555, 8'hAA);
        wr(21'h2AA, 8'h55);
        wr({b, 15'h0}, 8'h30);
    endtask
    task automatic pulse(input logic which);
        @(posedge mclk_in);
        if (which) finish <= 1'b1;
        else overrun <= 1'b1;
        @(posedge mclk_in);
        finish <= 1'b0;
        overrun <= 1'b0;
        repeat (2) @(posedge mclk_in);
    endtask

    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 6000) begin
            bad_count++;
            report_and_stop();
        end
    end

    // ========================================
    // Tests
    initial begin
        repeat (20) @(posedge mclk_in);
        #1 chk("reset rdata", 16'h0000, rdata_out);
        chk("reset query", 16'h0000, {15'h0, query_mode_out});
        @(posedge mclk_in);
        rst_b <= 1'b1;
        ce_b <= 1'b0;
        @(posedge mclk_in);
        #1 chk("rdy idle", 16'h0001, {15'h0, rdy_out});
        chk("idle rdata", 16'h0000 ^ 16'hA5C3, rdata_out);
        @(posedge mclk_in);
        oe_b <= 1'b0;
        @(posedge mclk_in);
        #1 chk("rdy wait", 16'h0000, {15'h0, rdy_out});
        @(posedge mclk_in);
        burst_valid <= 1'b1;
        @(posedge mclk_in);
        #1 chk("rdy valid", 16'h0001, {15'h0, rdy_out});
        @(posedge mclk_in);
        oe_b <= 1'b1;
        burst_valid <= 1'b0;
        wr(21'h055, 8'h98);
        #1 chk("query on", 16'h0001, {15'h0, query_mode_out});
        for (int i = 0; i < 32; i++) begin
            rd({14'h0, QA[i][6:0]}, d0);
            chk("query word", {8'h00, QD[i]}, d0);
        end
        wr(21'h000, 8'hF0);
        rd(21'h00123, d0);
        chk("array after reset", 16'h0123 ^ 16'hA5C3, d0);
        chk("query off", 16'h0000, {15'h0, query_mode_out});
        ers(6'd1);
        rd({6'd1, 15'h0}, d0);
        chk("window open", 16'h0000, {15'h0, d0[3]});
        wr({6'd2, 15'h0}, 8'h30);
        #1 chk("block mask", 16'h0006, erase_blk_mask_out[15:0]);
        n = 0;
        while (erase_start_out !== 1'b1 && n < 3 * WCYC) begin
            @(posedge mclk_in);
            #1 n++;
        end
        chk("window late", 16'h0001, {15'h0, n > 0 && n <= WCYC + 4});
        rd({6'd1, 15'h0}, d0);
        rd({6'd1, 15'h0}, d1);
        chk("window shut", 16'h0001, {15'h0, d0[3]});
        chk("toggle erase", 16'h0001, {15'h0, d0[2] ^ d1[2]});
        wr(21'h055, 8'h98);
        #1 chk("write ignored", 16'h0000, {15'h0, query_mode_out});
        chk("busy erase", 16'h0001, {15'h0, busy_out});
        wr(21'h000, 8'hB0);
        rd({6'd5, 15'h0}, d0);
        chk("suspend other", 16'h8000 ^ 16'hA5C3, d0);
        rd({6'd2, 15'h0}, d0);
        rd({6'd2, 15'h0}, d1);
        chk("toggle suspend", 16'h0001, {15'h0, d0[2] ^ d1[2]});
        wr(21'h555, 8'hAA);
        wr(21'h2AA, 8'h55);
        wr(21'h555, 8'hA0);
        wr({6'd5, 15'h4}, 8'h3C);
        rd({6'd5, 15'h4}, d0);
        chk("program in suspend", 16'h0001, {15'h0, d0[2]});
        pulse(1'b1);
        wr(21'h000, 8'h30);
        pulse(1'b1);
        chk("erase done", 16'h0000, {15'h0, busy_out});
        ers(6'd3);
        repeat (WCYC + 8) @(posedge mclk_in);
        pulse(1'b0);
        rd({6'd3, 15'h0}, d0);
        chk("exceeded flag", 16'h0001, {15'h0, d0[5]});
        @(posedge mclk_in);
        rst_b <= 1'b0;
        @(posedge mclk_in);
        #1 chk("reset busy", 16'h0000, {15'h0, busy_out});
        @(posedge mclk_in);
        rst_b <= 1'b1;
        rd({6'd3, 15'h0}, d0);
        chk("read after reset", 16'h8000 ^ 16'hA5C3, d0);
        report_and_stop();
    end
endmodule
`default_nettype wire
